// >>> design/gcg_map.svh
// Register offsets, field positions, reset values and codes of the global control block.
`ifndef GCG_MAP_SVH
`define GCG_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define GCG_OFS_MODE 8'h01
`define GCG_OFS_GSTAT 8'h03
`define GCG_OFS_DIRL 8'h04
`define GCG_OFS_DIRH 8'h05
`define GCG_OFS_DATL 8'h06
`define GCG_OFS_DATH 8'h07
`define GCG_OFS_IML 8'h08
`define GCG_OFS_IMH 8'h09
`define GCG_OFS_ISL 8'h0A
`define GCG_OFS_ISH 8'h0B

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GCG_BIT_EXT_DMA_ENABLE 6
`define GCG_BIT_STYLE_HI 5
`define GCG_BIT_STYLE_LO 4
`define GCG_BIT_OSC_POWER_DOWN 3
`define GCG_BIT_SHAPER_DISABLE 1
`define GCG_BIT_GIM 0
`define GCG_BIT_GPI 7
`define GCG_BIT_DMI 6

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define GCG_MODE_RST 8'h0B
`define GCG_MODE_WMASK 8'h7B
`define GCG_DIRL_RST 8'h07
`define GCG_DIRH_RST 8'hFF
`define GCG_IML_RST 8'h07
`define GCG_IMH_RST 8'hFF
`define GCG_HI_ONES 8'hB8

// ----------------------------------------------------------------------
// Interrupt pin style codes
// ----------------------------------------------------------------------
`define GCG_STY_OD_LOW 2'h0
`define GCG_STY_PP_LOW 2'h1
`define GCG_STY_RSVD 2'h2
`define GCG_STY_PP_HIGH 2'h3

`endif

// >>> design/gcg_pkg.sv
// Types shared by the global control block.
`include "gcg_map.svh"

package gcg_pkg;
   // Interrupt pin output style.
   typedef enum logic [1:0] {
      GCG_OD_LOW = `GCG_STY_OD_LOW,
      GCG_PP_LOW = `GCG_STY_PP_LOW,
      GCG_RSVD = `GCG_STY_RSVD,
      GCG_PP_HIGH = `GCG_STY_PP_HIGH
   } gcg_irq_style_t;
   typedef logic [7:0] gcg_byte_t;
   typedef logic [6:0] gcg_pins_t;
endpackage : gcg_pkg

// >>> design/gcg_pin_sync.sv
// Three-stage pin synchroniser with a debounced level and change pulse.
`timescale 1ns/1ps
`default_nettype none

module gcg_pin_sync (
   input wire logic clk, // System clock.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic pinIn, // Raw pin level.
   output logic level, // Accepted pin level.
   output logic change // One-cycle pulse on accepted change.
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   logic agree;

   // A change counts only once stages two and three agree.
   assign agree = (s2_r == s3_r);
   assign change = agree && (s3_r != level_r);
   assign level = level_r;

   // Stage one feeds stage two only, to keep metastability contained.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_r <= 1'b0;
      end else begin
         s1_r <= pinIn;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (change) begin
            level_r <= s3_r;
         end
      end
   end
endmodule : gcg_pin_sync

`default_nettype wire

// >>> design/gcg_global_ctrl.sv
// Global mode, global status and general purpose port of the controller.
`timescale 1ns/1ps
`default_nettype none
`include "gcg_map.svh"

module gcg_global_ctrl (
   input wire logic clk, // System clock, 100 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire gcg_pkg::gcg_byte_t regAddr, // Register address.
   input wire gcg_pkg::gcg_byte_t regWdata, // Write data.
   input wire logic regWr, // Write strobe.
   input wire logic regRd, // Read strobe.
   output gcg_pkg::gcg_byte_t regRdata, // Read data, cycle after strobe.
   input wire logic [5:0] chanPending, // A status 2..0, B status 2..0.
   input wire logic dmaPending, // Any DMA indication pending.
   output logic extDmaEnable, // External DMA support on.
   output logic oscPowerDown, // Oscillator held in power-down.
   output logic shaperDisable, // Clock shaper bypassed.
   input wire gcg_pkg::gcg_pins_t gpioIn, // Pins {10,9,8,6,2,1,0} in.
   output gcg_pkg::gcg_pins_t gpioOut, // Pin drive levels.
   output gcg_pkg::gcg_pins_t gpioOeN, // Pin enables, low drives.
   output logic irqOut, // Interrupt pin level.
   output logic irqOeN // Interrupt pin enable, low drives.
);
   import gcg_pkg::*;

   // ----------------------------------------------------------------------
   // Reset constants
   // ----------------------------------------------------------------------
   localparam gcg_byte_t DIRL_RST = `GCG_DIRL_RST;
   localparam gcg_byte_t DIRH_RST = `GCG_DIRH_RST;
   localparam gcg_byte_t IML_RST = `GCG_IML_RST;
   localparam gcg_byte_t IMH_RST = `GCG_IMH_RST;
   localparam gcg_pins_t DIR_RST = {DIRL_RST[2:0], DIRH_RST[6],
                                    DIRH_RST[2:0]};
   localparam gcg_pins_t IM_RST = {IML_RST[2:0], IMH_RST[6],
                                   IMH_RST[2:0]};

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   gcg_byte_t mode_r;
   gcg_byte_t mode_nxt;
   gcg_pins_t dir_r;
   gcg_pins_t dir_nxt;
   gcg_pins_t dat_r;
   gcg_pins_t dat_nxt;
   gcg_pins_t im_r;
   gcg_pins_t im_nxt;
   gcg_pins_t flag_r;
   gcg_pins_t flag_nxt;
   gcg_byte_t rdata_r;
   gcg_byte_t rdata_nxt;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   gcg_pins_t pinLevel;
   gcg_pins_t pinChange;

   // Each pin is sampled on its own so one slow pin never skews another.
   for (genvar i = 0; i < 7; i++) begin : g_sync
      gcg_pin_sync u_sync (
         .clk(clk),
         .rst(rst),
         .pinIn(gpioIn[i]),
         .level(pinLevel[i]),
         .change(pinChange[i])
      );
   end

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   logic wrMode;
   logic wrDirL;
   logic wrDirH;
   logic wrDatL;
   logic wrDatH;
   logic wrImL;
   logic wrImH;
   logic rdIsL;
   logic rdIsH;

   // Decode of write and read strobes per register.
   assign wrMode = regWr && (regAddr == `GCG_OFS_MODE);
   assign wrDirL = regWr && (regAddr == `GCG_OFS_DIRL);
   assign wrDirH = regWr && (regAddr == `GCG_OFS_DIRH);
   assign wrDatL = regWr && (regAddr == `GCG_OFS_DATL);
   assign wrDatH = regWr && (regAddr == `GCG_OFS_DATH);
   assign wrImL = regWr && (regAddr == `GCG_OFS_IML);
   assign wrImH = regWr && (regAddr == `GCG_OFS_IMH);
   assign rdIsL = regRd && (regAddr == `GCG_OFS_ISL);
   assign rdIsH = regRd && (regAddr == `GCG_OFS_ISH);

   // ----------------------------------------------------------------------
   // Byte packing of the seven pins
   // ----------------------------------------------------------------------
   // Index 6..4 are pins 10..8 (low byte), 3 is pin 6, 2..0 pins 2..0.
   function automatic gcg_byte_t toLo(input gcg_pins_t v);
      toLo = {5'h00, v[6:4]};
   endfunction : toLo

   function automatic gcg_byte_t toHi(input gcg_pins_t v);
      toHi = {1'b0, v[3], 3'h0, v[2:0]};
   endfunction : toHi

   // Only implemented bits are stored; the rest cannot change.
   function automatic gcg_pins_t merge(input gcg_pins_t old,
                                       input logic lo,
                                       input logic hi,
                                       input gcg_byte_t wd);
      merge = old;
      if (lo) begin
         merge[6:4] = wd[2:0];
      end
      if (hi) begin
         merge[3:0] = {wd[6], wd[2:0]};
      end
   endfunction : merge

   // ----------------------------------------------------------------------
   // Mode register and its control outputs
   // ----------------------------------------------------------------------
   gcg_irq_style_t style;
   logic global_irq_mask;

   // Unused mode bits 7 and 2 are forced low on every write.
   assign mode_nxt = wrMode ? (regWdata & `GCG_MODE_WMASK) : mode_r;
   assign extDmaEnable = mode_r[`GCG_BIT_EXT_DMA_ENABLE];
   assign oscPowerDown = mode_r[`GCG_BIT_OSC_POWER_DOWN];
   assign shaperDisable = mode_r[`GCG_BIT_SHAPER_DISABLE];
   assign global_irq_mask = mode_r[`GCG_BIT_GIM];
   assign style = gcg_irq_style_t'(mode_r[`GCG_BIT_STYLE_HI:
                                          `GCG_BIT_STYLE_LO]);

   // ----------------------------------------------------------------------
   // Port registers
   // ----------------------------------------------------------------------
   assign dir_nxt = merge(dir_r, wrDirL, wrDirH, regWdata);
   assign im_nxt = merge(im_r, wrImL, wrImH, regWdata);
   assign dat_nxt = merge(dat_r, wrDatL, wrDatH, regWdata);

   // Output pins drive the written level; a one in dir releases the pin.
   assign gpioOut = dat_r;
   assign gpioOeN = dir_r;

   // ----------------------------------------------------------------------
   // Port interrupt flags
   // ----------------------------------------------------------------------
   gcg_pins_t flagSet;
   gcg_pins_t flagClr;

   // Only input pins with a clear mask bit raise an indication.
   assign flagSet = pinChange & dir_r & ~im_r;
   // A read clears the flags of its own byte only.
   assign flagClr = {{3{rdIsL}}, {4{rdIsH}}};
   // A transition in the read cycle survives the clear.
   assign flag_nxt = (flag_r & ~flagClr) | flagSet;

   // ----------------------------------------------------------------------
   // Global status and interrupt pin
   // ----------------------------------------------------------------------
   gcg_byte_t gstat;
   logic anyPend;
   logic irqActive;

   // Status is combined live so it clears with its sources, no write needed.
   assign gstat = {|flag_r, dmaPending, chanPending};
   assign anyPend = |gstat;
   assign irqActive = !global_irq_mask && anyPend;

   // Reserved style falls back to open drain, which cannot fight the line.
   assign irqOut = (style == GCG_PP_HIGH) ? irqActive
                 : (style == GCG_PP_LOW) ? !irqActive : 1'b0;
   assign irqOeN = (style == GCG_PP_HIGH || style == GCG_PP_LOW) ? 1'b0
                 : !irqActive;

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   gcg_pins_t datView;
   gcg_byte_t rdMux;

   // Inputs read the accepted pin level, outputs read back the drive.
   assign datView = (dir_r & pinLevel) | (~dir_r & dat_r);

   always_comb begin
      unique case (regAddr)
         `GCG_OFS_MODE: rdMux = mode_r;
         `GCG_OFS_GSTAT: rdMux = gstat;
         `GCG_OFS_DIRL: rdMux = toLo(dir_r);
         `GCG_OFS_DIRH: rdMux = toHi(dir_r) | `GCG_HI_ONES;
         `GCG_OFS_DATL: rdMux = toLo(datView);
         `GCG_OFS_DATH: rdMux = toHi(datView);
         `GCG_OFS_IML: rdMux = toLo(im_r);
         `GCG_OFS_IMH: rdMux = toHi(im_r) | `GCG_HI_ONES;
         `GCG_OFS_ISL: rdMux = toLo(flag_r);
         `GCG_OFS_ISH: rdMux = toHi(flag_r);
         default: rdMux = 8'h00;
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   assign rdata_nxt = regRd ? rdMux : 8'h00;
   assign regRdata = rdata_r;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   // All control state comes out of reset at its documented value.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_r <= `GCG_MODE_RST;
         dir_r <= DIR_RST;
         im_r <= IM_RST;
         dat_r <= 7'h00;
         flag_r <= 7'h00;
         rdata_r <= 8'h00;
      end else begin
         mode_r <= mode_nxt;
         dir_r <= dir_nxt;
         im_r <= im_nxt;
         dat_r <= dat_nxt;
         flag_r <= flag_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   logic pinShowsActive;

   // Level the outside world sees as an active interrupt.
   assign pinShowsActive = (style == GCG_PP_HIGH) ? irqOut
                         : (style == GCG_PP_LOW) ? !irqOut : !irqOeN;

   a_mode_after_reset: assert property (
      $past(rst) |-> (mode_r == 8'h0B && oscPowerDown && shaperDisable))
      else $error("mode register not 0B after reset");

   a_gim_holds_idle: assert property (
      (regWr && regAddr == 8'h01 && regWdata[0]) |=> !pinShowsActive)
      else $error("interrupt pin active under global mask");

   a_irq_follows_pend: assert property (
      (!global_irq_mask && anyPend) |-> pinShowsActive)
      else $error("interrupt pin idle while indication pending");

   a_masked_no_flag: assert property (
      ((flag_r & ~$past(flag_r)) & $past(im_r | ~dir_r)) == 7'h00)
      else $error("flag raised on masked or output pin");

   a_flag_sticky: assert property (
      (flag_r[0] && !rdIsH) |=> flag_r[0])
      else $error("pin flag lost without a status read");

   a_read_clears: assert property (
      (rdIsH && pinChange[3:0] == 4'h0) |=>
      (flag_r[3:0] == 4'h0 && regRdata == toHi($past(flag_r))))
      else $error("status read did not return and clear flags");

   a_gstat_live: assert property (
      (regRd && regAddr == 8'h03) |=>
      (regRdata[7] == |$past(flag_r) && regRdata[6] == $past(dmaPending)))
      else $error("global status does not match sources");

   a_dirh_ones: assert property (
      (regRd && regAddr == 8'h05) |=> ((regRdata & 8'hB8) == 8'hB8))
      else $error("unused direction high bits not one");

   a_data_unused_zero: assert property (
      (regRd && regAddr == 8'h06) |=> (regRdata[7:3] == 5'h00))
      else $error("unused data bits not zero");

   a_out_pin_drive: assert property (
      (!dir_r[3]) |-> (!gpioOeN[3] && gpioOut[3] == dat_r[3]))
      else $error("output pin not driven from data");

   a_rdata_one_cycle: assert property (
      !regRd |=> (regRdata == 8'h00))
      else $error("read data outside the answer cycle");

   logic pendExp;

   // Activity rebuilt from the sources, so a slip in the pin logic shows.
   assign pendExp = !mode_r[0] && ((flag_r != 7'h00) || dmaPending
                                   || (chanPending != 6'h00));

   // Push-pull styles always drive, at the level that the style asks for.
   a_push_pull_level: assert property (
      mode_r[4] |-> (!irqOeN && irqOut == (mode_r[5] ~^ pendExp)))
      else $error("push-pull interrupt level wrong");

   // Open drain and the reserved code never pull the line high.
   a_open_drain_low: assert property (
      !mode_r[4] |-> (!irqOut && irqOeN == !pendExp))
      else $error("open-drain interrupt pin misdriven");

   // Each mode write reaches its control outputs on the next edge.
   a_mode_outputs: assert property (
      (regWr && regAddr == 8'h01) |=>
      (extDmaEnable == $past(regWdata[6])
       && oscPowerDown == $past(regWdata[3])
       && shaperDisable == $past(regWdata[1])))
      else $error("mode control outputs do not follow the write");

   // The channel bits pass through untouched.
   a_chan_status: assert property (
      (regRd && regAddr == 8'h03) |=>
      (regRdata[5:0] == $past(chanPending)))
      else $error("channel bits of global status wrong");

   // With nothing pending the summary reads clear without any write.
   a_gstat_idle: assert property (
      (regRd && regAddr == 8'h03 && flag_r == 7'h00 && !dmaPending
       && chanPending == 6'h00) |=> (regRdata == 8'h00))
      else $error("global status not clear with no source pending");

   // Unused high mask bits always read one.
   a_imh_ones: assert property (
      (regRd && regAddr == 8'h09) |=> ((regRdata & 8'hB8) == 8'hB8))
      else $error("unused mask high bits not one");

   // A low direction write lands on pins 10..8 one edge later.
   a_dirl_to_pins: assert property (
      (regWr && regAddr == 8'h04) |=>
      (gpioOeN[6:4] == $past(regWdata[2:0])))
      else $error("low direction write did not reach the pins");

   // An input pin reads back its accepted level.
   a_in_pin_reads: assert property (
      (regRd && regAddr == 8'h07 && dir_r[0]) |=>
      (regRdata[0] == $past(pinLevel[0])))
      else $error("input pin data does not show the pin level");

   // Cover points for the main scenarios.
   c_irq_raised: cover property (!global_irq_mask ##1 flagSet != 7'h00 ##1 pinShowsActive);
   c_status_cleared: cover property (flag_r[4] && rdIsL ##1 !flag_r[4]);
   c_set_wins: cover property (rdIsH && flagSet[0]);
   c_pp_high_active: cover property (mode_r[5:4] == 2'h3 && irqOut);
   c_masked_change: cover property (pinChange[0] && im_r[0] && dir_r[0]);

endmodule : gcg_global_ctrl

`default_nettype wire

// >>> testbench/gcg_pin_model.sv
// Far-side model: port pins and the interrupt line with its pull-up.
`timescale 1ns/1ps
`default_nettype none

module gcg_pin_model (
   input wire gcg_pkg::gcg_pins_t extDrive, // Level driven from outside.
   input wire gcg_pkg::gcg_pins_t gpioOut, // Device drive levels.
   input wire gcg_pkg::gcg_pins_t gpioOeN, // Device enables, low drives.
   input wire logic irqOut, // Device interrupt level.
   input wire logic irqOeN, // Device interrupt enable, low drives.
   output wire gcg_pkg::gcg_pins_t gpioIn, // Resolved pin levels.
   output wire logic irqLine // Resolved interrupt line.
);
   import gcg_pkg::*;
   // ---------------------------------------------------------------
   // Wire resolution
   // ---------------------------------------------------------------
   // The outside lets go of a pin that the device drives.
   // This avoids contention on output pins.
   assign gpioIn = (gpioOut & ~gpioOeN) | (extDrive & gpioOeN);
   // A released open-drain line floats up to its pull-up level.
   assign irqLine = (irqOeN === 1'b0) ? irqOut : 1'b1;
endmodule : gcg_pin_model

`default_nettype wire

// >>> testbench/tb_global_control_and_gpio.sv
// Self-checking bench of the global control and port block.
`timescale 1ns/1ps
`default_nettype none

module tb_global_control_and_gpio;
   import gcg_pkg::*;
   logic clk, rst, regWr, regRd, dmaPending;
   logic extDmaEnable, oscPowerDown, shaperDisable, irqOut, irqOeN, irqLine;
   gcg_byte_t regAddr, regWdata, regRdata;
   logic [5:0] chanPending;
   gcg_pins_t gpioIn, gpioOut, gpioOeN, extDrive;
   gcg_byte_t expQ[$];
   int n_fail = 0;
   int num_checks = 0;
   logic [31:0] seed = 32'd24734;

   gcg_global_ctrl dut_u (.clk(clk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .chanPending(chanPending),
      .dmaPending(dmaPending), .extDmaEnable(extDmaEnable),
      .oscPowerDown(oscPowerDown), .shaperDisable(shaperDisable),
      .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOeN(gpioOeN),
      .irqOut(irqOut), .irqOeN(irqOeN));
   gcg_pin_model pins_u (.extDrive(extDrive), .gpioOut(gpioOut),
      .gpioOeN(gpioOeN), .irqOut(irqOut), .irqOeN(irqOeN),
      .gpioIn(gpioIn), .irqLine(irqLine));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Clock of 10 ns.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Fixed-seed xorshift keeps runs repeatable.
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk(input gcg_byte_t seen, input gcg_byte_t exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic close_out();
      // A read whose answer was never compared is a failure too.
      if (expQ.size() != 0) begin
         n_fail++;
      end
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   task automatic wr(input gcg_byte_t a, input gcg_byte_t d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr

   // The expectation is queued before the strobe goes out.
   task automatic rd(input gcg_byte_t a, input gcg_byte_t e);
      expQ.push_back(e);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
   endtask : rd

   // Lets the edge after a write land before outputs are looked at.
   task automatic settle();
      @(posedge clk);
      #1;
   endtask : settle

   // Read data stand only in the cycle after the strobe, so look mid-cycle.
   always @(posedge clk) begin
      if (regRd === 1'b1) begin
         @(negedge clk);
         chk(regRdata, expQ.pop_front());
      end
   end

   // A hang counts as a failure and still reaches the verdict.
   initial begin
      #200us;
      n_fail++;
      close_out();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] v;
      regAddr = 8'h00;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      chanPending = 6'h00;
      dmaPending = 1'b0;
      extDrive = 7'h00;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      settle();
      chk({5'h0, extDmaEnable, oscPowerDown, shaperDisable}, 8'h03);
      chk({1'b0, gpioOeN}, 8'h7F);
      chk({7'h0, irqOeN}, 8'h01);
      rd(8'h01, 8'h0B);
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h07);
      rd(8'h05, 8'hFF);
      rd(8'h08, 8'h07);
      rd(8'h09, 8'hFF);
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      // Mode bits drive their outputs; reserved bits are dropped.
      wr(8'h01, 8'h40);
      settle();
      chk({5'h0, extDmaEnable, oscPowerDown, shaperDisable}, 8'h04);
      wr(8'h01, 8'hFF);
      rd(8'h01, 8'h7B);
      settle();
      chk({5'h0, extDmaEnable, oscPowerDown, shaperDisable}, 8'h07);
      // Global status follows its sources live.
      for (int i = 0; i < 4; i++) begin
         v = xs();
         chanPending <= v[5:0];
         dmaPending <= v[6];
         rd(8'h03, {1'b0, v[6], v[5:0]});
      end
      chanPending <= 6'h20;
      // Every pin style, with the global mask clear and then set.
      for (int s = 0; s < 4; s++) begin
         wr(8'h01, {2'b00, 2'(s), 4'h0});
         settle();
         chk({7'h0, irqLine}, 8'(s == 3));
         chk({7'h0, irqOeN}, 8'h00);
         wr(8'h01, {2'b00, 2'(s), 4'h1});
         settle();
         chk({7'h0, irqLine}, 8'(s != 3));
         chk({7'h0, irqOeN}, 8'(s[0] == 1'b0));
      end
      chanPending <= 6'h00;
      dmaPending <= 1'b0;
      // All pins as outputs with random levels.
      wr(8'h04, 8'h00);
      wr(8'h05, 8'h00);
      rd(8'h05, 8'hB8);
      v = xs();
      extDrive <= ~{v[2:0], v[14], v[10:8]};
      wr(8'h06, v[7:0]);
      wr(8'h07, v[15:8]);
      settle();
      chk({1'b0, gpioOeN}, 8'h00);
      chk({1'b0, gpioOut}, {1'b0, v[2:0], v[14], v[10:8]});
      rd(8'h06, {5'h0, v[2:0]});
      rd(8'h07, v[15:8] & 8'h47);
      // Inputs, unmasked, global mask clear, push-pull low.
      wr(8'h04, 8'h07);
      wr(8'h05, 8'hFF);
      extDrive <= 7'h00;
      // Let every pin settle while still masked, so no stray flag appears.
      repeat (8) @(posedge clk);
      wr(8'h08, 8'h00);
      wr(8'h09, 8'h00);
      rd(8'h09, 8'hB8);
      rd(8'h0A, 8'h00);
      rd(8'h0B, 8'h00);
      wr(8'h01, 8'h10);
      extDrive[0] <= 1'b1;
      repeat (8) @(posedge clk);
      rd(8'h03, 8'h80);
      settle();
      chk({7'h0, irqLine}, 8'h00);
      rd(8'h07, 8'h01);
      rd(8'h0B, 8'h01);
      rd(8'h0B, 8'h00);
      rd(8'h03, 8'h00);
      settle();
      chk({7'h0, irqLine}, 8'h01);
      extDrive[4] <= 1'b1;
      repeat (8) @(posedge clk);
      rd(8'h0A, 8'h01);
      rd(8'h0A, 8'h00);
      // A masked pin raises nothing.
      wr(8'h09, 8'h01);
      extDrive[0] <= 1'b0;
      repeat (8) @(posedge clk);
      rd(8'h0B, 8'h00);
      // The global mask silences the line but not the status.
      wr(8'h01, 8'h11);
      extDrive[1] <= 1'b1;
      repeat (8) @(posedge clk);
      settle();
      chk({7'h0, irqLine}, 8'h01);
      rd(8'h03, 8'h80);
      rd(8'h0B, 8'h02);
      repeat (3) @(posedge clk);
      close_out();
   end
endmodule : tb_global_control_and_gpio

`default_nettype wire
